// ---- rtl/cgad_pkg.sv ----
// Constants shared by the processor glue address decoder files
package cgad_pkg;
  // Address bit positions on the processor bus
  localparam int ADDR_IACK_BIT = 17;
  localparam int ADDR_PAGE_HI = 16;
  localparam int ADDR_PAGE_MID = 15;
  localparam int ADDR_PAGE_LO = 14;
  localparam int ADDR_LEVEL_BIT = 2;
  // Page layout: 16K byte pages, low four for program store
  localparam int PAGE_BYTES = 16384;
  localparam int ROM_PAGES = 4;
  localparam logic [23:0] RAM_ALIAS_BASE = 24'h014000;
  localparam logic [23:0] VEC_FETCH_FIRST = 24'hFFFFF0;
  localparam logic [23:0] VEC_FETCH_LAST = 24'hFFFFFF;
  // Positions inside the synchronised input vector
  localparam int SYNC_W = 10;
  localparam int S_A17 = 9;
  localparam int S_A16 = 8;
  localparam int S_A15 = 7;
  localparam int S_A14 = 6;
  localparam int S_A2 = 5;
  localparam int S_AS_N = 4;
  localparam int S_DS_N = 3;
  localparam int S_RW = 2;
  localparam int S_BUS_OWNER_BIT1 = 1;
  localparam int S_BUS_OWNER_BIT0 = 0;
  // Idle bus after reset: strobes high, read, processor owns the bus
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h01F;
  // Acknowledge state depth
  localparam int ACK_DEPTH = 3;
endpackage : cgad_pkg

// ---- rtl/cgad_sel_if.sv ----
// Decoded selects passed between the decoder, the acknowledge generator and the top
`timescale 1ns/1ns
interface cgad_sel_if;
  logic rom_sel;
  logic ram_sel;
  logic link_sel;
  logic uart_sel;
  logic link_iack;
  logic autovec;
  logic ram_wr;
  logic ram_rd;
  modport dec (output rom_sel, ram_sel, link_sel, uart_sel, link_iack, autovec, ram_wr, ram_rd);
  modport ack (input rom_sel, ram_sel);
  modport top (input rom_sel, ram_sel, link_sel, uart_sel, link_iack, autovec, ram_wr, ram_rd);
endinterface : cgad_sel_if

// ---- rtl/cgad_decoder.sv ----
// Combinational page and cycle decoder, active high selects
`timescale 1ns/1ns
module cgad_decoder (
  // Synchronised bus inputs
  input wire logic [cgad_pkg::SYNC_W-1:0] bus_s,
  // Decoded selects
  cgad_sel_if.dec sel
);
  logic strobe;
  logic own_cpu;
  logic own_dma;
  logic a16;
  logic a15;
  logic a14;

  // Only A16..A14 are looked at, so pages alias across the space
  assign strobe = !bus_s[cgad_pkg::S_AS_N];
  assign a16 = bus_s[cgad_pkg::S_A16];
  assign a15 = bus_s[cgad_pkg::S_A15];
  assign a14 = bus_s[cgad_pkg::S_A14];
  // Exactly one owner bit low marks a DMA cycle
  assign own_cpu = bus_s[cgad_pkg::S_BUS_OWNER_BIT1] & bus_s[cgad_pkg::S_BUS_OWNER_BIT0];
  assign own_dma = bus_s[cgad_pkg::S_BUS_OWNER_BIT1] ^ bus_s[cgad_pkg::S_BUS_OWNER_BIT0];

  // Four low pages to program store, one each to peripherals and RAM
  assign sel.rom_sel = strobe & !a16;
  assign sel.uart_sel = strobe & a16 & a15 & a14;
  assign sel.link_sel = strobe & a16 & a15 & !a14;

  // A17 is only high during a vector fetch; A2 splits the levels
  assign sel.link_iack = strobe & bus_s[cgad_pkg::S_A17] & bus_s[cgad_pkg::S_A2];
  assign sel.autovec = strobe & bus_s[cgad_pkg::S_A17] & !bus_s[cgad_pkg::S_A2];

  // RAM: A16 needed only while the processor owns the bus; A14 is not looked at, so page 5 aliases
  assign sel.ram_sel = strobe & !a15 & ((a16 & own_cpu) | own_dma);
  assign sel.ram_wr = sel.ram_sel & !bus_s[cgad_pkg::S_DS_N] & !bus_s[cgad_pkg::S_RW];
  assign sel.ram_rd = sel.ram_sel & !bus_s[cgad_pkg::S_DS_N] & bus_s[cgad_pkg::S_RW];
endmodule : cgad_decoder

// ---- rtl/cgad_ack_gen.sv ----
// Program store wait-state counter and acknowledge terms
`timescale 1ns/1ns
module cgad_ack_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Decoded selects
  cgad_sel_if.ack sel,
  // Acknowledge terms, active high
  output logic ack_normal,
  output logic ack_delayed,
  output logic ack_ram
);
  logic ack_state_first_r;
  logic ack_state_second_r;
  logic ack_state_third_r;

  // Shift chain; every bit is gated by the select so it restarts per access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_state_first_r <= 1'b0;
      ack_state_second_r <= 1'b0;
      ack_state_third_r <= 1'b0;
    end else begin
      ack_state_first_r <= sel.rom_sel;
      ack_state_second_r <= sel.rom_sel & ack_state_first_r;
      ack_state_third_r <= sel.rom_sel & ack_state_first_r & ack_state_second_r;
    end
  end

  // Delayed term gives slow EPROMs one more cycle
  assign ack_normal = ack_state_first_r & ack_state_second_r & sel.rom_sel;
  assign ack_delayed = ack_state_second_r & ack_state_third_r & sel.rom_sel;
  // Fast static RAM, no wait states
  assign ack_ram = sel.ram_sel;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_state_clear;
    !sel.rom_sel |=> !ack_state_first_r && !ack_state_second_r && !ack_state_third_r;
  endproperty
  a_state_clear: assert property (p_state_clear) else $error("ack state not cleared");

  property p_state_order;
    ack_state_third_r |-> ack_state_second_r && $past(ack_state_second_r);
  endproperty
  a_state_order: assert property (p_state_order) else $error("ack state order broken");
endmodule : cgad_ack_gen

// ---- rtl/cgad_top.sv ----
// Processor glue: address decoder, vector fetch split and memory acknowledges
//
// What this block does
// - Divide the space into 16K pages: four for program store, one each for link controller, UART pair and RAM.
// - Decode only partly, so RAM also answers at the page from 14000 and peripherals alias in their pages.
// - With address strobe, select program store on A16 low, UART pair on A16 A15 A14 high, link on A16 A15 high A14 low.
// - Detect a vector fetch by A17 high alone; fetches use FFFFF0 to FFFFFF and nothing else drives A17.
// - During a vector fetch with A2 high, acknowledge the link controller's level 2 interrupt.
// - During a vector fetch with A2 low, request the autovector for level 1 or level 4.
// - With strobe and A15 low, select RAM on A16 high with both owner bits high; write and read add data strobe.
// - With exactly one owner bit low, RAM select needs only strobe and A15 low; its enables add data strobe.
// - Each clock during a program store access the first state bit follows select, the next two fill in turn.
// - Give the normal program store acknowledge on the first two bits, the delayed one on the second and third.
// - The RAM acknowledge follows RAM select with no wait and is driven open drain.
// - Each acknowledge is released whenever its select is inactive.
// - The owner bits steer the buffer RAM select during DMA cycles.
`timescale 1ns/1ns
module cgad_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Processor bus, shared with the DMA master
  input wire logic [23:1] addr,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic bus_owner_bit1,
  input wire logic bus_owner_bit0,
  // Chip selects and enables, active low
  output logic prog_store_select_n,
  output logic buffer_mem_select_n,
  output logic link_ctrl_select_n,
  output logic uart_pair_select_n,
  output logic buffer_mem_write_n,
  output logic buffer_mem_read_n,
  // Vector fetch outputs, active low
  output logic link_ctrl_int_ack_n,
  output logic autovector_request_n,
  // Three-state program store acknowledges
  output logic prog_store_ack_normal_n,
  output logic prog_store_ack_normal_oe,
  output logic prog_store_ack_delayed_n,
  output logic prog_store_ack_delayed_oe,
  // Open-drain RAM acknowledge
  output logic buffer_mem_ack_n,
  output logic buffer_mem_ack_oe
);
  logic [cgad_pkg::SYNC_W-1:0] pins;
  logic [cgad_pkg::SYNC_W-1:0] sync_q1_r;
  logic [cgad_pkg::SYNC_W-1:0] sync_q2_r;
  logic ack_normal;
  logic ack_delayed;
  logic ack_ram;
  logic rom_sel_n_r;
  logic ram_sel_n_r;
  logic link_sel_n_r;
  logic uart_sel_n_r;
  logic ram_wr_n_r;
  logic ram_rd_n_r;
  logic link_iack_n_r;
  logic autovec_n_r;
  logic ack_normal_n_r;
  logic ack_normal_oe_r;
  logic ack_delayed_n_r;
  logic ack_delayed_oe_r;
  logic ack_ram_n_r;
  logic ack_ram_oe_r;

  cgad_sel_if sel ();

  // Gather the bus pins the decoder looks at
  assign pins[cgad_pkg::S_A17] = addr[cgad_pkg::ADDR_IACK_BIT];
  assign pins[cgad_pkg::S_A16] = addr[cgad_pkg::ADDR_PAGE_HI];
  assign pins[cgad_pkg::S_A15] = addr[cgad_pkg::ADDR_PAGE_MID];
  assign pins[cgad_pkg::S_A14] = addr[cgad_pkg::ADDR_PAGE_LO];
  assign pins[cgad_pkg::S_A2] = addr[cgad_pkg::ADDR_LEVEL_BIT];
  assign pins[cgad_pkg::S_AS_N] = address_strobe_n;
  assign pins[cgad_pkg::S_DS_N] = data_strobe_n;
  assign pins[cgad_pkg::S_RW] = read_write;
  assign pins[cgad_pkg::S_BUS_OWNER_BIT1] = bus_owner_bit1;
  assign pins[cgad_pkg::S_BUS_OWNER_BIT0] = bus_owner_bit0;

  // Two-stage synchroniser; costs latency but the bus is asynchronous to us
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_q1_r <= cgad_pkg::SYNC_RST;
      sync_q2_r <= cgad_pkg::SYNC_RST;
    end else begin
      sync_q1_r <= pins;
      sync_q2_r <= sync_q1_r;
    end
  end

  cgad_decoder u_decoder (
    .bus_s (sync_q2_r),
    .sel (sel.dec)
  );

  cgad_ack_gen u_ack_gen (
    .clk_sys (clk_sys),
    .rst (rst),
    .sel (sel.ack),
    .ack_normal (ack_normal),
    .ack_delayed (ack_delayed),
    .ack_ram (ack_ram)
  );

  // Registered chip selects and enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rom_sel_n_r <= 1'b1;
      ram_sel_n_r <= 1'b1;
      link_sel_n_r <= 1'b1;
      uart_sel_n_r <= 1'b1;
      ram_wr_n_r <= 1'b1;
      ram_rd_n_r <= 1'b1;
    end else begin
      rom_sel_n_r <= !sel.rom_sel;
      ram_sel_n_r <= !sel.ram_sel;
      link_sel_n_r <= !sel.link_sel;
      uart_sel_n_r <= !sel.uart_sel;
      ram_wr_n_r <= !sel.ram_wr;
      ram_rd_n_r <= !sel.ram_rd;
    end
  end

  // Registered vector fetch outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_iack_n_r <= 1'b1;
      autovec_n_r <= 1'b1;
    end else begin
      link_iack_n_r <= !sel.link_iack;
      autovec_n_r <= !sel.autovec;
    end
  end

  // Acknowledges; link and UART acks come from those parts, not from here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_normal_n_r <= 1'b1;
      ack_normal_oe_r <= 1'b0;
      ack_delayed_n_r <= 1'b1;
      ack_delayed_oe_r <= 1'b0;
      ack_ram_n_r <= 1'b1;
      ack_ram_oe_r <= 1'b0;
    end else begin
      ack_normal_n_r <= !ack_normal;
      ack_normal_oe_r <= sel.rom_sel;
      ack_delayed_n_r <= !ack_delayed;
      ack_delayed_oe_r <= sel.rom_sel;
      ack_ram_n_r <= 1'b0; // Open drain: only ever pulls low
      ack_ram_oe_r <= ack_ram;
    end
  end

  // Ports straight from the flip-flops
  assign prog_store_select_n = rom_sel_n_r;
  assign buffer_mem_select_n = ram_sel_n_r;
  assign link_ctrl_select_n = link_sel_n_r;
  assign uart_pair_select_n = uart_sel_n_r;
  assign buffer_mem_write_n = ram_wr_n_r;
  assign buffer_mem_read_n = ram_rd_n_r;
  assign link_ctrl_int_ack_n = link_iack_n_r;
  assign autovector_request_n = autovec_n_r;
  assign prog_store_ack_normal_n = ack_normal_n_r;
  assign prog_store_ack_normal_oe = ack_normal_oe_r;
  assign prog_store_ack_delayed_n = ack_delayed_n_r;
  assign prog_store_ack_delayed_oe = ack_delayed_oe_r;
  assign buffer_mem_ack_n = ack_ram_n_r;
  assign buffer_mem_ack_oe = ack_ram_oe_r;

  // Helper view of the synchronised bus, read only by the checks below
  logic s_as;
  logic s_ds;
  logic s_rd;
  logic s_a17;
  logic s_a16;
  logic s_a15;
  logic s_a14;
  logic s_a2;
  logic s_cpu;
  logic s_dma;
  assign s_as = !sync_q2_r[cgad_pkg::S_AS_N];
  assign s_ds = !sync_q2_r[cgad_pkg::S_DS_N];
  assign s_rd = sync_q2_r[cgad_pkg::S_RW];
  assign s_a17 = sync_q2_r[cgad_pkg::S_A17];
  assign s_a16 = sync_q2_r[cgad_pkg::S_A16];
  assign s_a15 = sync_q2_r[cgad_pkg::S_A15];
  assign s_a14 = sync_q2_r[cgad_pkg::S_A14];
  assign s_a2 = sync_q2_r[cgad_pkg::S_A2];
  assign s_cpu = sync_q2_r[cgad_pkg::S_BUS_OWNER_BIT1] && sync_q2_r[cgad_pkg::S_BUS_OWNER_BIT0];
  assign s_dma = sync_q2_r[cgad_pkg::S_BUS_OWNER_BIT1] != sync_q2_r[cgad_pkg::S_BUS_OWNER_BIT0];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A pin level reaches its output three edges later
  property p_rom_page;
    (s_as && !s_a16) |=> !prog_store_select_n;
  endproperty
  a_rom_page: assert property (p_rom_page) else $error("program store select missing");

  property p_periph_pages;
    s_as && s_a16 && s_a15 |=> (uart_pair_select_n == !$past(s_a14) && link_ctrl_select_n == $past(s_a14));
  endproperty
  a_periph_pages: assert property (p_periph_pages) else $error("peripheral page select wrong");

  property p_select_idle;
    !s_as |=> prog_store_select_n && buffer_mem_select_n && link_ctrl_select_n && uart_pair_select_n;
  endproperty
  a_select_idle: assert property (p_select_idle) else $error("select without strobe");

  property p_vector_split;
    s_as && s_a17 |=> (link_ctrl_int_ack_n == !$past(s_a2) && autovector_request_n == $past(s_a2));
  endproperty
  a_vector_split: assert property (p_vector_split) else $error("vector fetch split wrong");

  property p_no_fetch;
    !s_a17 |=> link_ctrl_int_ack_n && autovector_request_n;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("vector output outside fetch");

  property p_ram_cpu;
    s_cpu |=> buffer_mem_select_n == !$past(s_as && s_a16 && !s_a15);
  endproperty
  a_ram_cpu: assert property (p_ram_cpu) else $error("RAM select wrong for processor");

  property p_ram_dma;
    s_dma |=> (buffer_mem_select_n == !$past(s_as && !s_a15)) &&
      (buffer_mem_write_n == !$past(s_as && !s_a15 && s_ds && !s_rd));
  endproperty
  a_ram_dma: assert property (p_ram_dma) else $error("RAM select wrong for DMA");

  property p_ram_enables;
    !buffer_mem_select_n |-> buffer_mem_read_n == !$past(s_ds && s_rd);
  endproperty
  a_ram_enables: assert property (p_ram_enables) else $error("RAM read enable wrong");

  // Select held over several clocks before each acknowledge
  sequence s_rom_three;
    sel.rom_sel [*3];
  endsequence
  sequence s_rom_four;
    sel.rom_sel [*4];
  endsequence
  sequence s_rom_restart;
    !sel.rom_sel ##1 sel.rom_sel;
  endsequence

  property p_ack_normal;
    s_rom_three |=> !prog_store_ack_normal_n && prog_store_ack_normal_oe;
  endproperty
  a_ack_normal: assert property (p_ack_normal) else $error("normal ack late");

  property p_ack_delayed;
    s_rom_four |=> !prog_store_ack_delayed_n && prog_store_ack_delayed_oe;
  endproperty
  a_ack_delayed: assert property (p_ack_delayed) else $error("delayed ack late");

  property p_ack_restart;
    s_rom_restart |=> prog_store_ack_normal_n ##1 prog_store_ack_delayed_n;
  endproperty
  a_ack_restart: assert property (p_ack_restart) else $error("ack did not wait afresh");

  property p_ack_release;
    !sel.rom_sel |=> !prog_store_ack_normal_oe && !prog_store_ack_delayed_oe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("program store ack not released");

  // Ack level leaves its reset value one edge after release, so look one edge on
  property p_ram_ack;
    1'b1 |=> !buffer_mem_ack_n && (buffer_mem_ack_oe == !buffer_mem_select_n);
  endproperty
  a_ram_ack: assert property (p_ram_ack) else $error("RAM ack not following select");

  // Program store acks stay idle outside their page; peripherals answer for themselves
  property p_ack_idle;
    !sel.rom_sel |=> prog_store_ack_normal_n && prog_store_ack_delayed_n;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("program store ack outside its page");

  property p_ack_oe_follow;
    prog_store_ack_normal_oe == !prog_store_select_n && prog_store_ack_delayed_oe == !prog_store_select_n;
  endproperty
  a_ack_oe_follow: assert property (p_ack_oe_follow) else $error("ack enable not tracking select");

  property p_rom_high_page;
    s_as && s_a16 |=> prog_store_select_n;
  endproperty
  a_rom_high_page: assert property (p_rom_high_page) else $error("program store selected above its pages");

  property p_page_exclusive;
    !prog_store_select_n |-> link_ctrl_select_n && uart_pair_select_n;
  endproperty
  a_page_exclusive: assert property (p_page_exclusive) else $error("program store overlaps a peripheral");

  property p_ram_write;
    !buffer_mem_select_n |-> buffer_mem_write_n == !$past(s_ds && !s_rd);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("RAM write enable wrong");

  property p_ram_dma_read;
    s_dma |=> buffer_mem_read_n == !$past(s_as && !s_a15 && s_ds && s_rd);
  endproperty
  a_ram_dma_read: assert property (p_ram_dma_read) else $error("RAM read enable wrong for DMA");
endmodule : cgad_top

// ---- verif/cgad_bus_model.sv ----
// Processor bus master model: drives address, strobes and owner bits
`timescale 1ns/1ns
module cgad_bus_model (
  // Clock
  input wire logic clk_sys,
  // Processor bus
  output logic [23:1] addr,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic read_write,
  output logic bus_owner_bit1,
  output logic bus_owner_bit0
);
  // Idle bus: strobes pulled high, processor owns the bus
  initial begin
    addr = 23'h000000;
    address_strobe_n = 1'h1;
    data_strobe_n = 1'h1;
    read_write = 1'h1;
    {bus_owner_bit1, bus_owner_bit0} = 2'h3;
  end
  // Peripheral acknowledges come from the peripherals, so none is modelled here
  // Start a cycle just after an edge; it stands until stop_cycle
  task automatic start_cycle(input logic [23:0] byte_addr, input logic rd, input logic ds, input logic [1:0] own);
    @(posedge clk_sys);
    #1;
    addr = byte_addr[23:1];
    read_write = rd;
    {bus_owner_bit1, bus_owner_bit0} = own;
    address_strobe_n = 1'h0;
    data_strobe_n = ~ds;
  endtask : start_cycle
  // Release; address lines float, shown inverted so stale values never match
  task automatic stop_cycle();
    @(posedge clk_sys);
    #1;
    address_strobe_n = 1'h1;
    data_strobe_n = 1'h1;
    read_write = 1'h1;
    addr = ~addr;
    {bus_owner_bit1, bus_owner_bit0} = 2'h3;
  endtask : stop_cycle
endmodule : cgad_bus_model

// ---- verif/cpu_glue_address_decoder_test.sv ----
// Self-checking bench for the processor glue address decoder
`timescale 1ns/1ns
module cpu_glue_address_decoder_test;
  // Clock, reset and bus
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [23:1] addr;
  logic address_strobe_n, data_strobe_n, read_write, bus_owner_bit1, bus_owner_bit0;
  // Design outputs
  logic prog_store_select_n, buffer_mem_select_n, link_ctrl_select_n, uart_pair_select_n;
  logic buffer_mem_write_n, buffer_mem_read_n, link_ctrl_int_ack_n, autovector_request_n;
  logic prog_store_ack_normal_n, prog_store_ack_normal_oe, prog_store_ack_delayed_n, prog_store_ack_delayed_oe;
  logic buffer_mem_ack_n, buffer_mem_ack_oe;
  int n_errors = 0;
  int n_checks = 0;
  wire logic [3:0] sel_n = {prog_store_select_n, buffer_mem_select_n, link_ctrl_select_n, uart_pair_select_n};

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  cgad_bus_model u_bus (.clk_sys(clk_sys), .addr(addr), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .bus_owner_bit1(bus_owner_bit1),
    .bus_owner_bit0(bus_owner_bit0));

  cgad_top u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .bus_owner_bit1(bus_owner_bit1),
    .bus_owner_bit0(bus_owner_bit0), .prog_store_select_n(prog_store_select_n),
    .buffer_mem_select_n(buffer_mem_select_n), .link_ctrl_select_n(link_ctrl_select_n),
    .uart_pair_select_n(uart_pair_select_n), .buffer_mem_write_n(buffer_mem_write_n),
    .buffer_mem_read_n(buffer_mem_read_n), .link_ctrl_int_ack_n(link_ctrl_int_ack_n),
    .autovector_request_n(autovector_request_n), .prog_store_ack_normal_n(prog_store_ack_normal_n),
    .prog_store_ack_normal_oe(prog_store_ack_normal_oe), .prog_store_ack_delayed_n(prog_store_ack_delayed_n),
    .prog_store_ack_delayed_oe(prog_store_ack_delayed_oe), .buffer_mem_ack_n(buffer_mem_ack_n),
    .buffer_mem_ack_oe(buffer_mem_ack_oe));

  // Single bit compare
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit
  // Select group compare, order prog, buffer, link, uart
  task automatic chk_sel(input logic [3:0] got, input logic [3:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_sel
  // Pins set just after edge N show on the outputs after edge N+3
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Outputs idle while reset is held
  task automatic test_reset();
    chk_sel(sel_n, 4'hF, "reset selects");
    chk_bit(prog_store_ack_normal_oe | prog_store_ack_delayed_oe | buffer_mem_ack_oe, 1'h0, "reset oe");
    $display("test reset done");
  endtask : test_reset

  // Wait states, then a back-to-back access must count afresh
  task automatic test_rom();
    u_bus.start_cycle(24'h00C000, 1'h1, 1'h1, 2'h3);
    settle();
    chk_sel(sel_n, 4'h7, "rom select");
    chk_bit(prog_store_ack_normal_oe & prog_store_ack_delayed_oe, 1'h1, "rom oe");
    chk_bit(prog_store_ack_normal_n, 1'h1, "normal E");
    step();
    chk_bit(prog_store_ack_normal_n, 1'h1, "normal E+1");
    step();
    chk_bit(prog_store_ack_normal_n, 1'h0, "normal E+2");
    chk_bit(prog_store_ack_delayed_n, 1'h1, "delayed E+2");
    step();
    chk_bit(prog_store_ack_delayed_n, 1'h0, "delayed E+3");
    u_bus.stop_cycle();
    u_bus.start_cycle(24'h000000, 1'h1, 1'h1, 2'h3);
    settle();
    chk_sel(sel_n, 4'h7, "rom again");
    chk_bit(prog_store_ack_normal_n & prog_store_ack_delayed_n, 1'h1, "acks restart");
    u_bus.stop_cycle();
    settle();
    chk_sel(sel_n, 4'hF, "idle");
    chk_bit(prog_store_ack_normal_oe | prog_store_ack_delayed_oe, 1'h0, "rom oe off");
    $display("test rom done");
  endtask : test_rom

  // Reads in pages 0 and 3 to 7, boundaries and aliases included
  task automatic test_pages();
    logic [23:0] pa [8] = '{24'h000000, 24'h00FFFE, 24'h010000, 24'h014000,
                           24'h018000, 24'h01A002, 24'h01C000, 24'h01E001};
    logic [3:0] ps [8] = '{4'h7, 4'h7, 4'hB, 4'hB, 4'hD, 4'hD, 4'hE, 4'hE};
    for (int i = 0; i < 8; i++) begin
      u_bus.start_cycle(pa[i], 1'h1, 1'h1, 2'h3);
      settle();
      chk_sel(sel_n, ps[i], "page select");
      chk_bit(buffer_mem_read_n, ps[i][2], "ram read");
      chk_bit(buffer_mem_ack_oe, ~ps[i][2], "ram ack");
      chk_bit(prog_store_ack_normal_oe | prog_store_ack_delayed_oe, ~ps[i][3], "rom ack oe");
      u_bus.stop_cycle();
    end
    $display("test pages done");
  endtask : test_pages

  // RAM enables for processor and DMA owners; controls are rd, ds, owner bits
  task automatic test_ram();
    logic [23:0] ra [7] = '{24'h010000, 24'h010000, 24'h000000, 24'h004000, 24'h008000, 24'h010000, 24'h000000};
    logic [3:0] rc [7] = '{4'h7, 4'h3, 4'h6, 4'hD, 4'hD, 4'hC, 4'hF};
    logic [2:0] re [7] = '{3'h1, 3'h3, 3'h1, 3'h2, 3'h7, 3'h7, 3'h7};
    for (int i = 0; i < 7; i++) begin
      u_bus.start_cycle(ra[i], rc[i][3], rc[i][2], rc[i][1:0]);
      settle();
      chk_bit(buffer_mem_select_n, re[i][2], "ram select");
      chk_bit(buffer_mem_write_n, re[i][1], "ram write");
      chk_bit(buffer_mem_read_n, re[i][0], "ram read");
      chk_bit(buffer_mem_ack_oe, ~re[i][2], "ram ack oe");
      chk_bit(buffer_mem_ack_n, 1'h0, "ram ack low");
      u_bus.stop_cycle();
    end
    $display("test ram done");
  endtask : test_ram

  // Vector fetches split on A2; a plain A2 read raises neither
  task automatic test_vector();
    logic [23:0] va [5] = '{24'hFFFFF4, 24'hFFFFF0, 24'hFFFFFC, 24'hFFFFF8, 24'h000004};
    logic [1:0] ve [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 5; i++) begin
      u_bus.start_cycle(va[i], 1'h1, 1'h1, 2'h3);
      settle();
      chk_bit(link_ctrl_int_ack_n, ve[i][1], "link iack");
      chk_bit(autovector_request_n, ve[i][0], "autovector");
      u_bus.stop_cycle();
    end
    $display("test vector done");
  endtask : test_vector

  // Main sequence; two reset edges clear both sync stages and the outputs
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    test_reset();
    rst = 1'h0;
    test_rom();
    test_pages();
    test_ram();
    test_vector();
    close_out();
  end

  // Watchdog, well beyond the 118 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : cpu_glue_address_decoder_test
